// [logic/can_access_pkg.sv]
// Constants and types for the indexed CAN register access path
package can_access_pkg;
  localparam logic [7:0] CAN_PAGE_VALUE = 8'h01;
  localparam logic [7:0] SFR_CONTROL = 8'hF8;
  localparam logic [7:0] SFR_TEST = 8'hDB;
  localparam logic [7:0] SFR_STATUS = 8'hC0;
  localparam logic [7:0] SFR_INDEX_POINTER = 8'hDA;
  localparam logic [7:0] SFR_DATA_HIGH = 8'hD9;
  localparam logic [7:0] SFR_DATA_LOW = 8'hD8;
  localparam int REG_WORDS = 128;
  localparam int NUM_OBJECTS = 32;
  localparam int OBJ_WORDS = 9;
  localparam int RAM_WORDS = 288;
  localparam logic [6:0] IDX_CONTROL = 7'h00;
  localparam logic [6:0] IDX_STATUS = 7'h01;
  localparam logic [6:0] IDX_ERROR = 7'h02;
  localparam logic [6:0] IDX_BIT_TIMING = 7'h03;
  localparam logic [6:0] IDX_INTERRUPT = 7'h04;
  localparam logic [6:0] IDX_TEST = 7'h05;
  localparam logic [6:0] IDX_PRESCALER_EXT = 7'h06;
  localparam logic [6:0] IDX_IF1_BASE = 7'h08;
  localparam logic [6:0] IDX_IF1_LAST = 7'h12;
  localparam logic [6:0] IDX_IF2_BASE = 7'h20;
  localparam logic [6:0] IDX_IF2_LAST = 7'h2A;
  localparam logic [6:0] IDX_TX_REQUEST = 7'h40;
  localparam logic [6:0] IDX_NEW_DATA = 7'h48;
  localparam logic [6:0] IDX_INT_PENDING = 7'h50;
  localparam logic [6:0] IDX_OBJECT_VALID = 7'h58;
  localparam logic [6:0] IF_CMD_MASK_OFS = 7'h01;
  localparam logic [6:0] IF_OBJECT_OFS = 7'h02;
  localparam logic [15:0] RST_CONTROL = 16'h0001;
  localparam logic [15:0] RST_BIT_TIMING = 16'h2301;
  localparam logic [15:0] RST_CMD_REQUEST = 16'h0001;
  localparam logic [15:0] RST_MASK = 16'hFFFF;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam int INIT_BIT = 0;
  localparam int CCE_BIT = 6;
  localparam int TEST_EN_BIT = 7;
  localparam int RX_BIT = 7;
  localparam int CMD_WRITE_BIT = 7;
  localparam int POST_LSB = 12;
  localparam int PRE_LSB = 8;
  localparam int SJW_LSB = 6;
  localparam int ARB2_WORD = 3;
  localparam int CTRL_WORD = 4;
  localparam int OBJ_VALID_BIT = 15;
  localparam int NEW_DATA_BIT = 15;
  localparam int INT_PEND_BIT = 13;
  localparam int TX_REQ_BIT = 8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_wr;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_idx;
  } host_req_type;

  typedef struct packed {
    logic [3:0] post_sample_segment_field;
    logic [3:0] pre_sample_segment_field;
    logic [1:0] jump_width_field;
    logic [16:0] quantum_prescaler;
  } timing_type;
endpackage

// [logic/can_indexed_register_access.sv]
// Indexed and direct host access to the CAN controller register space
// Operation
// - 128 sixteen-bit registers, each by index
// - Data ports reach indexed register high/low bytes
// - Bit timing register sits at index 0x03
// - Low data port accepts single-bit writes
// - Control, test, status also directly at F8/DB/C0
// - All other registers reachable only by index
// - Bit timing packs post, pre, jump; the prescaler comes from the extension
// - Command request write moves object data
// - Two interface sets serve 32 message objects
// - Message handler flag registers are read-only
// - Low port access autoincrements within interface ranges
// - Bit timing writable only with change enable
// - Prescaler equals extension plus one, reset one
module can_indexed_register_access
  import can_access_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire host_req_type host_req_in,
  input wire logic can_rx_in,
  output logic [7:0] rdata_out,
  output logic [6:0] index_pointer_out,
  output logic [15:0] control_out,
  output timing_type timing_out
);

  logic [15:0] word_q [REG_WORDS];
  logic [15:0] word_d [REG_WORDS];
  logic [15:0] ram_q [RAM_WORDS];
  logic [15:0] ram_d [RAM_WORDS];
  logic [6:0] index_q;
  logic [6:0] index_d;
  logic [7:0] stage_q;
  logic [7:0] stage_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [15:0] control_q;
  logic [15:0] control_d;
  timing_type timing_q;
  timing_type timing_d;
  logic rx_meta_q;
  logic rx_sync_q;
  logic rx_meta_d;
  logic rx_sync_d;

  function automatic logic [15:0] reset_value(input int idx);
    logic [6:0] i;
    i = 7'(idx);
    if (i == IDX_CONTROL)
    begin
      return RST_CONTROL;
    end
    if (i == IDX_BIT_TIMING)
    begin
      return RST_BIT_TIMING;
    end
    if (i == IDX_IF1_BASE || i == IDX_IF2_BASE)
    begin
      return RST_CMD_REQUEST;
    end
    if (i == IDX_IF1_BASE + 7'h02 || i == IDX_IF1_BASE + 7'h03 ||
        i == IDX_IF2_BASE + 7'h02 || i == IDX_IF2_BASE + 7'h03)
    begin
      return RST_MASK;
    end
    return RST_ZERO;
  endfunction

  function automatic logic in_iface(input logic [6:0] i);
    return (i >= IDX_IF1_BASE && i <= IDX_IF1_LAST) ||
           (i >= IDX_IF2_BASE && i <= IDX_IF2_LAST);
  endfunction

  // Write permission; unimplemented and flag words never take a write
  function automatic logic writable(input logic [6:0] i, input logic [15:0] ctrl);
    if (i == IDX_BIT_TIMING)
    begin
      return ctrl[CCE_BIT];
    end
    // Prescaler extension unlocks with the test bit, not with change enable
    if (i == IDX_PRESCALER_EXT)
    begin
      return ctrl[TEST_EN_BIT];
    end
    return i == IDX_CONTROL || i == IDX_STATUS || i == IDX_TEST || in_iface(i);
  endfunction

  function automatic logic [7:0] set_bit(input logic [7:0] cur, input logic [2:0] pos,
                                         input logic val);
    logic [7:0] r;
    r = cur;
    r[pos] = val;
    return r;
  endfunction

  // Each flag register pair covers sixteen objects per word
  function automatic logic [6:0] flag_index(input logic [6:0] first, input int k);
    return first + 7'(k / 16);
  endfunction

  logic direct_hit;
  logic low_hit;
  logic on_page;
  logic any_access;
  logic [6:0] tgt;
  logic [15:0] cur;
  logic [15:0] new_word;
  logic [6:0] base;
  logic [5:0] obj;
  int unsigned slot;

  always_comb
  begin
    word_d = word_q;
    ram_d = ram_q;
    index_d = index_q;
    stage_d = stage_q;
    rdata_d = 8'h00;
    tgt = index_q;
    new_word = 16'h0000;
    base = IDX_IF1_BASE;
    obj = 6'h00;
    slot = 0;
    on_page = host_req_in.page == CAN_PAGE_VALUE;
    any_access = host_req_in.wr | host_req_in.rd | host_req_in.bit_wr;
    low_hit = on_page && host_req_in.addr == SFR_DATA_LOW;
    direct_hit = on_page && (host_req_in.addr == SFR_CONTROL ||
                             host_req_in.addr == SFR_TEST ||
                             host_req_in.addr == SFR_STATUS);
    if (host_req_in.addr == SFR_TEST)
    begin
      tgt = IDX_TEST;
    end
    else if (host_req_in.addr == SFR_STATUS)
    begin
      tgt = IDX_STATUS;
    end
    else if (host_req_in.addr == SFR_CONTROL)
    begin
      tgt = IDX_CONTROL;
    end
    if (low_hit)
    begin
      tgt = index_q;
    end
    cur = word_q[tgt];

    if (on_page && host_req_in.addr == SFR_INDEX_POINTER)
    begin
      if (host_req_in.wr)
      begin
        index_d = host_req_in.wdata[6:0];
      end
      if (host_req_in.rd)
      begin
        rdata_d = {1'b0, index_q};
      end
    end

    if (on_page && host_req_in.addr == SFR_DATA_HIGH)
    begin
      if (host_req_in.wr)
      begin
        stage_d = host_req_in.wdata;
      end
      if (host_req_in.rd)
      begin
        rdata_d = word_q[index_q][15:8];
      end
    end

    if (low_hit || direct_hit)
    begin
      if (host_req_in.rd)
      begin
        rdata_d = cur[7:0];
      end
      if (host_req_in.wr || host_req_in.bit_wr)
      begin
        if (host_req_in.bit_wr)
        begin
          // Bit write keeps the stored high byte, not the staged one
          new_word = {cur[15:8], set_bit(cur[7:0], host_req_in.bit_idx,
                                         host_req_in.wdata[0])};
        end
        else if (low_hit)
        begin
          new_word = {stage_q, host_req_in.wdata};
        end
        else
        begin
          new_word = {cur[15:8], host_req_in.wdata};
        end
        if (writable(tgt, word_q[IDX_CONTROL]))
        begin
          word_d[tgt] = new_word;
          if (tgt == IDX_IF1_BASE || tgt == IDX_IF2_BASE)
          begin
            // Object numbers run 1..32; 0 and above 32 move nothing
            // The copy ends in the write cycle, so software never polls a busy bit
            base = tgt;
            obj = new_word[5:0];
            if (obj != 6'h00 && obj <= 6'(NUM_OBJECTS))
            begin
              slot = (int'(obj) - 1) * OBJ_WORDS;
              for (int j = 0; j < OBJ_WORDS; j++)
              begin
                if (word_q[base + IF_CMD_MASK_OFS][CMD_WRITE_BIT])
                begin
                  ram_d[slot + j] = word_q[base + IF_OBJECT_OFS + 7'(j)];
                end
                else
                begin
                  word_d[base + IF_OBJECT_OFS + 7'(j)] = ram_q[slot + j];
                end
              end
            end
          end
        end
      end
      if (low_hit && any_access && in_iface(index_q))
      begin
        index_d = index_q + 7'h01;
      end
    end

    // Test register receive bit follows the bus, not software
    word_d[IDX_TEST][RX_BIT] = rx_sync_q;

    for (int k = 0; k < NUM_OBJECTS; k++)
    begin
      word_d[flag_index(IDX_TX_REQUEST, k)][k % 16] =
        ram_d[k * OBJ_WORDS + CTRL_WORD][TX_REQ_BIT];
      word_d[flag_index(IDX_NEW_DATA, k)][k % 16] =
        ram_d[k * OBJ_WORDS + CTRL_WORD][NEW_DATA_BIT];
      word_d[flag_index(IDX_INT_PENDING, k)][k % 16] =
        ram_d[k * OBJ_WORDS + CTRL_WORD][INT_PEND_BIT];
      word_d[flag_index(IDX_OBJECT_VALID, k)][k % 16] =
        ram_d[k * OBJ_WORDS + ARB2_WORD][OBJ_VALID_BIT];
    end

    timing_d.post_sample_segment_field = word_d[IDX_BIT_TIMING][POST_LSB +: 4];
    timing_d.pre_sample_segment_field = word_d[IDX_BIT_TIMING][PRE_LSB +: 4];
    timing_d.jump_width_field = word_d[IDX_BIT_TIMING][SJW_LSB +: 2];
    timing_d.quantum_prescaler = {1'b0, word_d[IDX_PRESCALER_EXT]} + 17'h00001;
    control_d = word_d[IDX_CONTROL];
    // Pin is asynchronous; only the second stage feeds the test register
    rx_meta_d = can_rx_in;
    rx_sync_d = rx_meta_q;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < REG_WORDS; i++)
      begin
        word_q[i] <= reset_value(i);
      end
      for (int i = 0; i < RAM_WORDS; i++)
      begin
        ram_q[i] <= RST_ZERO;
      end
      index_q <= 7'h00;
      stage_q <= 8'h00;
      rdata_q <= 8'h00;
      control_q <= RST_CONTROL;
      timing_q.post_sample_segment_field <= RST_BIT_TIMING[POST_LSB +: 4];
      timing_q.pre_sample_segment_field <= RST_BIT_TIMING[PRE_LSB +: 4];
      timing_q.jump_width_field <= RST_BIT_TIMING[SJW_LSB +: 2];
      timing_q.quantum_prescaler <= 17'h00001;
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end
    else
    begin
      word_q <= word_d;
      ram_q <= ram_d;
      index_q <= index_d;
      stage_q <= stage_d;
      rdata_q <= rdata_d;
      control_q <= control_d;
      timing_q <= timing_d;
      rx_meta_q <= rx_meta_d;
      rx_sync_q <= rx_sync_d;
    end
  end

  assign rdata_out = rdata_q;
  assign index_pointer_out = index_q;
  assign control_out = control_q;
  assign timing_out = timing_q;

endmodule

// [testbench/can_access_asserts.sv]
// Port checker for the indexed CAN register access block
module can_access_asserts
  import can_access_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire host_req_type host_req_in,
  input wire logic can_rx_in,
  input wire logic [7:0] rdata_out,
  input wire logic [6:0] index_pointer_out,
  input wire logic [15:0] control_out,
  input wire timing_type timing_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic [7:0] stage_q;
  logic [7:0] stage_d;
  logic pg;
  logic lo_acc;
  logic ix_wr;
  logic in_rng;
  assign pg = host_req_in.page == CAN_PAGE_VALUE;
  assign lo_acc = |{host_req_in.wr, host_req_in.rd, host_req_in.bit_wr} && pg
    && host_req_in.addr == SFR_DATA_LOW;
  assign ix_wr = host_req_in.wr && pg && host_req_in.addr == SFR_INDEX_POINTER;
  assign in_rng = (index_pointer_out >= IDX_IF1_BASE && index_pointer_out <= IDX_IF1_LAST)
    || (index_pointer_out >= IDX_IF2_BASE && index_pointer_out <= IDX_IF2_LAST);
  // Shadow of the staged high byte, so the packing check needs no design internals
  always_comb
  begin
    stage_d = stage_q;
    if (host_req_in.wr && pg && host_req_in.addr == SFR_DATA_HIGH)
      stage_d = host_req_in.wdata;
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      stage_q <= 8'h00;
    else
      stage_q <= stage_d;
  end
  sequence s_idx3;
    ix_wr && host_req_in.wdata == 8'h03;
  endsequence
  sequence s_high;
    host_req_in.wr && pg && host_req_in.addr == SFR_DATA_HIGH;
  endsequence
  sequence s_low_cce;
    lo_acc && host_req_in.wr && control_out[CCE_BIT];
  endsequence
  sequence s_low_ext;
    lo_acc && host_req_in.wr && index_pointer_out == IDX_PRESCALER_EXT
      && control_out[TEST_EN_BIT];
  endsequence
  AST_TIMING_PACK: assert property (s_idx3 ##1 s_high ##1 s_low_cce |=>
    {timing_out[26:23], timing_out[22:19]} == $past(stage_q)
    && timing_out.jump_width_field == $past(host_req_in.wdata[7:6]))
    else $error("bit timing fields do not match staged and low bytes");
  AST_INDEX_LOAD: assert property (ix_wr |=>
    index_pointer_out == $past(host_req_in.wdata[6:0]))
    else $error("index pointer not loaded");
  AST_AUTOINC: assert property (lo_acc && in_rng |=>
    index_pointer_out == $past(index_pointer_out) + 7'h01)
    else $error("index pointer did not advance");
  AST_INDEX_STILL: assert property (!ix_wr && !(lo_acc && in_rng) |=>
    $stable(index_pointer_out))
    else $error("index pointer moved without cause");
  AST_TIMING_LOCK: assert property (!control_out[CCE_BIT] |=> $stable(timing_out[26:17]))
    else $error("bit timing changed while locked");
  AST_PRESC_LOCK: assert property (!control_out[TEST_EN_BIT] |=>
    $stable(timing_out.quantum_prescaler))
    else $error("prescaler changed while locked");
  AST_PRESC_LOAD: assert property (s_low_ext |=>
    timing_out.quantum_prescaler == {1'b0, $past(stage_q), $past(host_req_in.wdata)} + 17'h00001)
    else $error("prescaler not loaded from staged and low bytes");
  AST_PRESC_NONZERO: assert property (timing_out.quantum_prescaler != 17'h00000)
    else $error("prescaler is zero");
  AST_RD_IDLE: assert property (!(host_req_in.rd && pg) |=> rdata_out == 8'h00)
    else $error("read data without a read");
  AST_CTRL_DIRECT: assert property (host_req_in.wr && pg && host_req_in.addr == SFR_CONTROL |=>
    (control_out[7:0] & 8'hC1) == ($past(host_req_in.wdata) & 8'hC1)
    && $stable(control_out[15:8]))
    else $error("direct control write not taken");
  AST_RESET_STATE: assert property ($fell(rst_in) |-> index_pointer_out == 7'h00
    && control_out == RST_CONTROL && timing_out == {4'h2, 4'h3, 2'h0, 17'h00001})
    else $error("reset state wrong");
endmodule
bind can_indexed_register_access can_access_asserts can_access_asserts_inst (.clk_sys_in,
  .rst_in, .host_req_in, .can_rx_in, .rdata_out, .index_pointer_out, .control_out, .timing_out);

// [testbench/can_host_model.sv]
// Host core model issuing page-qualified byte accesses
module can_host_model
  import can_access_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic [7:0] rdata_in,
  output host_req_type host_req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial host_req_out = '0;
  // Released fields flip so a stale address or byte is never taken as live
  function automatic host_req_type idle();
    host_req_type v;
    v = ~host_req_out;
    v.wr = 1'b0;
    v.rd = 1'b0;
    v.bit_wr = 1'b0;
    return v;
  endfunction
  task automatic acc(logic [2:0] k, logic [7:0] p, logic [7:0] a, logic [7:0] d,
    logic [2:0] i, output logic [7:0] q);
    host_req_out <= '{k[2], k[1], k[0], p, a, d, i};
    @(posedge clk_sys_in);
    host_req_out <= idle();
    @(negedge clk_sys_in);
    q = rdata_in;
    @(posedge clk_sys_in);
  endtask
  task automatic wr8(logic [7:0] p, logic [7:0] a, logic [7:0] d);
    logic [7:0] q;
    acc(3'h4, p, a, d, 3'h0, q);
  endtask
  task automatic rd8(logic [7:0] a, output logic [7:0] q);
    acc(3'h2, CAN_PAGE_VALUE, a, 8'h00, 3'h0, q);
  endtask
  // Index, then high, then low, back to back
  task automatic wr16(logic [6:0] x, logic [15:0] v);
    logic [7:0] q;
    host_req_out <= '{1'b1, 1'b0, 1'b0, CAN_PAGE_VALUE, SFR_INDEX_POINTER, {1'b0, x}, 3'h0};
    @(posedge clk_sys_in);
    host_req_out <= '{1'b1, 1'b0, 1'b0, CAN_PAGE_VALUE, SFR_DATA_HIGH, v[15:8], 3'h0};
    @(posedge clk_sys_in);
    acc(3'h4, CAN_PAGE_VALUE, SFR_DATA_LOW, v[7:0], 3'h0, q);
  endtask
  task automatic rd16(logic [6:0] x, output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    wr8(CAN_PAGE_VALUE, SFR_INDEX_POINTER, {1'b0, x});
    rd8(SFR_DATA_HIGH, h);
    rd8(SFR_DATA_LOW, l);
    v = {h, l};
  endtask
  function automatic logic [15:0] bt_word(int prop, int ph1, int ph2);
    int resync_jump_width;
    resync_jump_width = (ph1 < 4) ? ph1 : 4;
    return 16'((ph2 - 1) * 32'h1000 + (prop + ph1 - 1) * 32'h0100
      + (resync_jump_width - 1) * 32'h0040);
  endfunction
endmodule

// [testbench/tb_can_indexed_register_access.sv]
// Self-checking bench for the indexed CAN register access block
module tb_can_indexed_register_access;
  import can_access_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic can_rx_in = 1'b1;
  host_req_type req;
  logic [7:0] rdata;
  logic [6:0] index_ptr;
  logic [15:0] control;
  timing_type timing;
  int err_count = 0;
  int tests_run = 0;
  logic [7:0] b;
  logic [15:0] w;
  logic [15:0] bt;
  always #25 clk_sys_in = ~clk_sys_in;
  can_indexed_register_access can_indexed_register_access_inst (.clk_sys_in, .rst_in,
    .host_req_in(req), .can_rx_in, .rdata_out(rdata), .index_pointer_out(index_ptr),
    .control_out(control), .timing_out(timing));
  can_host_model can_host_model_inst (.clk_sys_in, .rdata_in(rdata), .host_req_out(req));
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk(timing, {4'h2, 4'h3, 2'h0, 17'h00001});
    can_host_model_inst.rd16(IDX_BIT_TIMING, w);
    chk(w, RST_BIT_TIMING);
    can_host_model_inst.rd16(7'h0A, w);
    chk(w, RST_MASK);
    bt = can_host_model_inst.bt_word(9, 6, 6);
    can_host_model_inst.wr16(IDX_BIT_TIMING, bt);
    chk(timing, {4'h2, 4'h3, 2'h0, 17'h00001});
    // Init and change enable before timing, as a careful host does
    can_host_model_inst.wr8(CAN_PAGE_VALUE, SFR_CONTROL, 8'h41);
    can_host_model_inst.rd16(IDX_CONTROL, w);
    chk(w, 16'h0041);
    chk(control, 16'h0041);
    can_host_model_inst.wr16(IDX_BIT_TIMING, bt);
    chk(timing, {bt[15:12], bt[11:8], bt[7:6], 17'h00001});
    can_host_model_inst.wr8(CAN_PAGE_VALUE, SFR_DATA_HIGH, 8'h11);
    can_host_model_inst.rd16(IDX_BIT_TIMING, w);
    chk(w, bt);
    can_host_model_inst.acc(3'h1, CAN_PAGE_VALUE, SFR_DATA_LOW, 8'h01, 3'h0, b);
    can_host_model_inst.rd16(IDX_BIT_TIMING, w);
    chk(w, bt | 16'h0001);
    can_host_model_inst.acc(3'h1, CAN_PAGE_VALUE, SFR_DATA_LOW, 8'h00, 3'h6, b);
    can_host_model_inst.rd16(IDX_BIT_TIMING, w);
    chk(w, (bt | 16'h0001) & 16'hFFBF);
    chk(timing.jump_width_field, 2'h2);
    can_host_model_inst.wr8(CAN_PAGE_VALUE, SFR_CONTROL, 8'hC1);
    can_host_model_inst.wr16(IDX_PRESCALER_EXT, 16'h0004);
    chk(timing.quantum_prescaler, 17'h00005);
    can_host_model_inst.wr8(8'h02, SFR_CONTROL, 8'h00);
    can_host_model_inst.rd8(SFR_CONTROL, b);
    chk(b, 8'hC1);
    can_host_model_inst.rd8(8'hC1, b);
    chk(b, 8'h00);
    can_rx_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    can_host_model_inst.rd8(SFR_TEST, b);
    chk(b[7], 1'b0);
    can_host_model_inst.wr8(CAN_PAGE_VALUE, SFR_STATUS, 8'h18);
    can_host_model_inst.rd16(IDX_STATUS, w);
    chk(w, 16'h0018);
    can_host_model_inst.wr16(IDX_IF1_BASE + IF_CMD_MASK_OFS, 16'h0080);
    for (int k = 0; k < 9; k++)
    begin
      can_host_model_inst.wr8(CAN_PAGE_VALUE, SFR_DATA_HIGH, 8'hA0);
      can_host_model_inst.wr8(CAN_PAGE_VALUE, SFR_DATA_LOW, 8'(k));
    end
    chk(index_ptr, 7'h13);
    can_host_model_inst.wr16(IDX_IF1_BASE, 16'h0005);
    can_host_model_inst.wr16(IDX_OBJECT_VALID, 16'h0000);
    can_host_model_inst.rd16(IDX_OBJECT_VALID, w);
    chk(w, 16'h0010);
    can_host_model_inst.wr16(IDX_IF2_BASE + IF_CMD_MASK_OFS, 16'h0000);
    can_host_model_inst.wr16(IDX_IF2_BASE, 16'h0005);
    can_host_model_inst.rd16(7'h27, w);
    chk(w, 16'hA005);
    complete_run();
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys_in);
    err_count++;
    complete_run();
  end
endmodule
